// File: verif/shift_return_flag_ops_test.sv
// self-checking bench for the shift, rotate, borrow, flag and return unit
// assumes srfo_core from verilog/ and its package are compiled first
`timescale 1ns/1ps
module shift_return_flag_ops_test;
   logic                core_clk = 1'b0;
   logic                resetn = 1'b0;
   logic                op_valid = 1'b0;
   srfo_pkg::srfo_req_s op_req = '0;
   logic                ld_valid = 1'b0;
   srfo_pkg::srfo_ld_s  ld_data = '0;
   logic                mem_ack = 1'b0;
   logic [15:0]         mem_rdata = 16'h5A5A;
   logic                op_ready;
   logic                result_valid;
   logic                op_done;
   logic                mem_req;
   logic [15:0]         result;
   logic [15:0]         pc;
   logic [15:0]         sp;
   logic [15:0]         sr;
   logic [15:0]         mem_addr;
   logic [15:0]         exp_pc;
   logic [15:0]         exp_stk;
   logic [15:0]         exp_stat;
   logic [15:0]         exp_res = 16'h0000;
   logic [15:0]         corner [8] = '{16'h3FFF, 16'h4000, 16'hBFFF, 16'hC000,
                                       16'hA53F, 16'h5A40, 16'hFFBF, 16'h00C0};
   integer              seed = 77;
   integer              n_fail = 0;
   integer              tests_run = 0;
   integer              i;
   integer              j;

   always #5 core_clk = ~core_clk;

   srfo_core DUT (
      .core_clk     (core_clk),
      .resetn       (resetn),
      .op_valid     (op_valid),
      .op_req       (op_req),
      .op_ready     (op_ready),
      .result       (result),
      .result_valid (result_valid),
      .op_done      (op_done),
      .ld_valid     (ld_valid),
      .ld_data      (ld_data),
      .pc           (pc),
      .sp           (sp),
      .sr           (sr),
      .mem_req      (mem_req),
      .mem_addr     (mem_addr),
      .mem_ack      (mem_ack),
      .mem_rdata    (mem_rdata)
   );

   task chk(input logic [15:0] got, input logic [15:0] exp);
      begin
         tests_run++;
         if (got !== exp)
         begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task print_verdict;
      begin
         if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   // returns {result, status}; works on a 17-bit copy so carry out is visible
   function automatic logic [31:0] model(input srfo_pkg::srfo_op_e op, input logic bt,
                                         input logic rg, input logic [15:0] d,
                                         input logic [15:0] s);
      logic [16:0] w;
      logic [16:0] r;
      logic        c;
      logic        v;
      int          m;
      begin
         if (op == srfo_pkg::OP_FORCE_CARRY_FLAG)
            return {16'h0000, s | 16'h0001};
         if (op == srfo_pkg::OP_FORCE_NEGATIVE_FLAG)
            return {16'h0000, s | 16'h0004};
         if (op == srfo_pkg::OP_FORCE_ZERO_FLAG)
            return {16'h0000, s | 16'h0002};
         m = bt ? 7 : 15;
         w = bt ? {9'h000, d[7:0]} : {1'b0, d};
         c = w[m];
         v = bt ? (w >= 17'h40 && w < 17'hC0) : (w >= 17'h4000 && w < 17'hC000);
         case (op)
            srfo_pkg::OP_ARITH_SHIFT_LEFT: r = w << 1;
            srfo_pkg::OP_ROTATE_LEFT_THRU_CARRY: r = (w << 1) | s[0];
            srfo_pkg::OP_ARITH_SHIFT_RIGHT: r = (w >> 1) | (w[m] << m);
            srfo_pkg::OP_ROTATE_RIGHT_THRU_CARRY: r = (w >> 1) | (s[0] << m);
            default: r = w + (bt ? 17'h000FF : 17'h0FFFF) + s[0];
         endcase
         if (op == srfo_pkg::OP_ARITH_SHIFT_RIGHT || op == srfo_pkg::OP_ROTATE_RIGHT_THRU_CARRY)
         begin
            c = w[0];
            v = 1'b0;
         end
         if (op == srfo_pkg::OP_SUBTRACT_BORROW_ONLY)
         begin
            c = r[m + 1];
            v = w[m] & ~r[m];
         end
         r = r & (bt ? 17'h000FF : 17'h0FFFF);
         s[0] = c;
         s[1] = (r == 17'h0);
         s[2] = r[m];
         s[8] = v;
         return {(bt ? {(rg ? 8'h00 : d[15:8]), r[7:0]} : r[15:0]), s};
      end
   endfunction

   // starts at a falling edge and leaves op_valid high for back-to-back use
   task issue(input srfo_pkg::srfo_op_e op, input logic bt, input logic rg,
              input logic [15:0] d);
      logic [31:0] e;
      begin
         op_req = '{op, bt, rg, d};
         op_valid = 1'b1;
         // ready is combinational on ld_valid: read it only once it has settled
         #1;
         // a stuck ready is left to the watchdog
         while (op_ready !== 1'b1)
            @(negedge core_clk);
         e = model(op, bt, rg, d, exp_stat);
         @(negedge core_clk);
         exp_stat = e[15:0];
         if (op < srfo_pkg::OP_FORCE_CARRY_FLAG)
         begin
            exp_res = e[31:16];
            chk({15'h0, result_valid}, 16'h0001);
         end
         else
            chk({15'h0, result_valid}, 16'h0000);
         chk(result, exp_res);
         chk(sr, exp_stat);
         chk({15'h0, op_done}, 16'h0001);
      end
   endtask

   task load(input logic [15:0] p, input logic [15:0] k, input logic [15:0] s);
      begin
         ld_data = '{p, k, s};
         ld_valid = 1'b1;
         #1;
         chk({15'h0, op_ready}, 16'h0000);
         @(negedge core_clk);
         ld_valid = 1'b0;
         exp_pc = p;
         exp_stk = k;
         exp_stat = s;
         chk(pc, p);
         chk(sp, k);
         chk(sr, s);
      end
   endtask

   // irq selects the two-word pop; stalls the acknowledge 0..2 cycles
   task pop_seq(input logic irq, input logic [15:0] w0, input logic [15:0] w1);
      int k;
      int d;
      begin
         op_req = '{(irq ? srfo_pkg::OP_INTERRUPT_RETURN : srfo_pkg::OP_SUBROUTINE_RETURN),
                    1'b0, 1'b0, 16'h0000};
         op_valid = 1'b1;
         @(negedge core_clk);
         op_valid = 1'b0;
         for (k = irq ? 0 : 1; k < 2; k++)
         begin
            d = $unsigned($random(seed)) % 3;
            repeat (d)
            begin
               chk({15'h0, op_ready}, 16'h0000);
               @(negedge core_clk);
            end
            chk({15'h0, mem_req}, 16'h0001);
            chk(mem_addr, exp_stk);
            mem_ack = 1'b1;
            mem_rdata = k ? w1 : w0;
            @(negedge core_clk);
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
            exp_stk = exp_stk + 16'h0002;
            if (k == 0)
            begin
               exp_stat = w0;
               chk(sr, w0);
            end
            else
               exp_pc = w1;
         end
         chk(pc, exp_pc);
         chk(sp, exp_stk);
         chk(sr, exp_stat);
         chk({15'h0, op_done}, 16'h0001);
      end
   endtask

   task check_reset;
      begin
         exp_pc = srfo_pkg::RST_PC;
         exp_stk = srfo_pkg::RST_SP;
         exp_stat = srfo_pkg::RST_SR;
         exp_res = 16'h0000;
         chk(pc, exp_pc);
         chk(sp, exp_stk);
         chk(sr, exp_stat);
         chk(result, exp_res);
         chk({14'h0, result_valid, op_done}, 16'h0000);
      end
   endtask

   initial
   begin
      repeat (2) @(negedge core_clk);
      resetn = 1'b1;
      check_reset;
      load(16'h1234, 16'h0300, 16'h0038);
      for (i = 0; i < 5; i++)
         for (j = 0; j < 8; j++)
         begin
            if (j % 2 == 1)
               issue(srfo_pkg::OP_FORCE_CARRY_FLAG, 1'b0, 1'b0, 16'h0000);
            issue(srfo_pkg::srfo_op_e'(i + 2), j >= 4, j[0], corner[j]);
         end
      op_valid = 1'b0;
      @(negedge core_clk);
      load(16'($random(seed)), 16'h0200, 16'($random(seed)) & 16'h013F);
      for (i = 0; i < 300; i++)
         issue(srfo_pkg::srfo_op_e'(2 + $unsigned($random(seed)) % 8),
               1'($random(seed)), 1'($random(seed)), 16'($random(seed)));
      op_valid = 1'b0;
      @(negedge core_clk);
      for (i = 0; i < 8; i++)
      begin
         pop_seq(i[0], 16'($random(seed)) & 16'h013F, 16'($random(seed)));
         issue(srfo_pkg::OP_ARITH_SHIFT_RIGHT, 1'b0, 1'b1, 16'($random(seed)));
         op_valid = 1'b0;
         @(negedge core_clk);
      end
      resetn = 1'b0;
      @(negedge core_clk);
      check_reset;
      resetn = 1'b1;
      @(negedge core_clk);
      issue(srfo_pkg::OP_SUBTRACT_BORROW_ONLY, 1'b1, 1'b1, 16'h7700);
      op_valid = 1'b0;
      print_verdict;
   end

   // far beyond the roughly 405 to 429 cycles the sequence needs
   initial
   begin
      #100000;
      n_fail++;
      print_verdict;
   end
endmodule

// File: verilog/srfo_core.sv
// execution unit for shifts, rotates, borrow-only subtract, flag forcing
// and the two return sequences; owns pc, stack pointer and status register
// assumes the stack read port answers on the core_clk domain
`timescale 1ns/1ps

module srfo_core (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               resetn,
   // operation request
   input  wire logic               op_valid,
   input  srfo_pkg::srfo_req_s     op_req,
   output logic                    op_ready,
   // operation answer
   output logic [15:0]             result,
   output logic                    result_valid,
   output logic                    op_done,
   // architectural state
   input  wire logic               ld_valid,
   input  srfo_pkg::srfo_ld_s      ld_data,
   output logic [15:0]             pc,
   output logic [15:0]             sp,
   output logic [15:0]             sr,
   // stack read port
   output logic                    mem_req,
   output logic [15:0]             mem_addr,
   input  wire logic               mem_ack,
   input  wire logic [15:0]        mem_rdata
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_POP_SR,
      ST_POP_PC
   } srfo_state_e;

   srfo_state_e state_r;
   logic [15:0] pc_r;
   logic [15:0] sp_r;
   logic [15:0] sr_r;
   logic [15:0] result_r;
   logic        result_valid_r;
   logic        op_done_r;

   logic        taken;
   logic        is_alu;
   logic        is_flag;
   logic        is_ret;
   logic        pop_sr_ack;
   logic        pop_pc_ack;
   logic [15:0] opnd;
   logic        cin;
   logic [15:0] w_res;
   logic [7:0]  b_res;
   logic        w_cy;
   logic        b_cy;
   logic        w_ov;
   logic        b_ov;
   logic [16:0] sum_w;
   logic [8:0]  sum_b;
   logic [15:0] res;
   logic        flag_c;
   logic        flag_v;
   logic        flag_n;
   logic        flag_z;
   logic [15:0] sr_alu;
   logic [15:0] flag_mask;

   // handshakes are combinational; loads take priority over new work
   assign op_ready   = (state_r == ST_IDLE) && !ld_valid;
   assign taken      = op_valid && op_ready;
   assign mem_req    = (state_r != ST_IDLE);
   assign mem_addr   = sp_r;
   assign pop_sr_ack = (state_r == ST_POP_SR) && mem_ack;
   assign pop_pc_ack = (state_r == ST_POP_PC) && mem_ack;

   assign pc           = pc_r;
   assign sp           = sp_r;
   assign sr           = sr_r;
   assign result       = result_r;
   assign result_valid = result_valid_r;
   assign op_done      = op_done_r;

   always_comb
   begin
      is_alu  = 1'b0;
      is_flag = 1'b0;
      is_ret  = 1'b0;
      case (op_req.op)
         srfo_pkg::OP_SUBROUTINE_RETURN,
         srfo_pkg::OP_INTERRUPT_RETURN:    is_ret  = 1'b1;
         srfo_pkg::OP_FORCE_CARRY_FLAG,
         srfo_pkg::OP_FORCE_NEGATIVE_FLAG,
         srfo_pkg::OP_FORCE_ZERO_FLAG:     is_flag = 1'b1;
         default:                          is_alu  = 1'b1;
      endcase
   end

   // word and byte results are both formed; the size bit picks one
   always_comb
   begin
      opnd  = op_req.operand;
      cin   = sr_r[srfo_pkg::C_BIT];
      w_res = opnd;
      b_res = opnd[7:0];
      w_cy  = 1'b0;
      b_cy  = 1'b0;
      w_ov  = 1'b0;
      b_ov  = 1'b0;
      sum_w = {1'b0, srfo_pkg::ONES_W} + {1'b0, opnd} + {16'h0000, cin};
      sum_b = {1'b0, srfo_pkg::ONES_B} + {1'b0, opnd[7:0]} + {8'h00, cin};
      case (op_req.op)
         srfo_pkg::OP_ARITH_SHIFT_LEFT:
         begin
            w_res = {opnd[14:0], 1'b0};
            b_res = {opnd[6:0], 1'b0};
            w_cy  = opnd[15];
            b_cy  = opnd[7];
            w_ov  = (opnd >= srfo_pkg::OVF_W_LO) && (opnd < srfo_pkg::OVF_W_HI);
            b_ov  = (opnd[7:0] >= srfo_pkg::OVF_B_LO) && (opnd[7:0] < srfo_pkg::OVF_B_HI);
         end
         srfo_pkg::OP_ROTATE_LEFT_THRU_CARRY:
         begin
            w_res = {opnd[14:0], cin};
            b_res = {opnd[6:0], cin};
            w_cy  = opnd[15];
            b_cy  = opnd[7];
            w_ov  = (opnd >= srfo_pkg::OVF_W_LO) && (opnd < srfo_pkg::OVF_W_HI);
            b_ov  = (opnd[7:0] >= srfo_pkg::OVF_B_LO) && (opnd[7:0] < srfo_pkg::OVF_B_HI);
         end
         srfo_pkg::OP_ARITH_SHIFT_RIGHT:
         begin
            w_res = {opnd[15], opnd[15:1]};
            b_res = {opnd[7], opnd[7:1]};
            w_cy  = opnd[0];
            b_cy  = opnd[0];
         end
         srfo_pkg::OP_ROTATE_RIGHT_THRU_CARRY:
         begin
            w_res = {cin, opnd[15:1]};
            b_res = {cin, opnd[7:1]};
            w_cy  = opnd[0];
            b_cy  = opnd[0];
         end
         srfo_pkg::OP_SUBTRACT_BORROW_ONLY:
         begin
            w_res = sum_w[15:0];
            b_res = sum_b[7:0];
            w_cy  = sum_w[16];
            b_cy  = sum_b[8];
            // second addend is negative, so overflow is a sign drop
            w_ov  = opnd[15] && !sum_w[15];
            b_ov  = opnd[7] && !sum_b[7];
         end
         default:
         begin
            w_res = opnd;
         end
      endcase
   end

   // memory destinations keep their upper byte; only the low lane is written
   always_comb
   begin
      if (op_req.byte_op)
      begin
         res    = {(op_req.dst_is_reg ? 8'h00 : opnd[15:8]), b_res};
         flag_c = b_cy;
         flag_v = b_ov;
         flag_n = b_res[7];
         flag_z = (b_res == 8'h00);
      end
      else
      begin
         res    = w_res;
         flag_c = w_cy;
         flag_v = w_ov;
         flag_n = w_res[15];
         flag_z = (w_res == 16'h0000);
      end
   end

   // only the four arithmetic flags move; mode bits pass through
   always_comb
   begin
      sr_alu                     = sr_r;
      sr_alu[srfo_pkg::C_BIT]    = flag_c;
      sr_alu[srfo_pkg::Z_BIT]    = flag_z;
      sr_alu[srfo_pkg::N_BIT]    = flag_n;
      sr_alu[srfo_pkg::V_BIT]    = flag_v;
      case (op_req.op)
         srfo_pkg::OP_FORCE_CARRY_FLAG:    flag_mask = srfo_pkg::SET_C_MASK;
         srfo_pkg::OP_FORCE_NEGATIVE_FLAG: flag_mask = srfo_pkg::SET_N_MASK;
         srfo_pkg::OP_FORCE_ZERO_FLAG:     flag_mask = srfo_pkg::SET_Z_MASK;
         default:                          flag_mask = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         state_r <= ST_IDLE;
      else
         case (state_r)
            ST_IDLE:
               if (taken && op_req.op == srfo_pkg::OP_SUBROUTINE_RETURN)
                  state_r <= ST_POP_PC;
               else if (taken && op_req.op == srfo_pkg::OP_INTERRUPT_RETURN)
                  state_r <= ST_POP_SR;
            ST_POP_SR:
               if (mem_ack)
                  state_r <= ST_POP_PC;
            ST_POP_PC:
               if (mem_ack)
                  state_r <= ST_IDLE;
            default:
               state_r <= ST_IDLE;
         endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         sr_r <= srfo_pkg::RST_SR;
      else if (ld_valid && state_r == ST_IDLE)
         sr_r <= ld_data.sr;
      else if (pop_sr_ack)
         sr_r <= mem_rdata;
      else if (taken && is_alu)
         sr_r <= sr_alu;
      else if (taken && is_flag)
         sr_r <= sr_r | flag_mask;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pc_r <= srfo_pkg::RST_PC;
         sp_r <= srfo_pkg::RST_SP;
      end
      else if (ld_valid && state_r == ST_IDLE)
      begin
         pc_r <= ld_data.pc;
         sp_r <= ld_data.sp;
      end
      else
      begin
         if (pop_pc_ack)
            pc_r <= mem_rdata;
         if (pop_sr_ack || pop_pc_ack)
            sp_r <= sp_r + srfo_pkg::STACK_STEP;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         result_r       <= 16'h0000;
         result_valid_r <= 1'b0;
         op_done_r      <= 1'b0;
      end
      else
      begin
         if (taken && is_alu)
            result_r <= res;
         result_valid_r <= taken && is_alu;
         op_done_r      <= (taken && !is_ret) || pop_pc_ack;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_ret_pc_sp: assert property (
      pop_pc_ack |=> pc_r == $past(mem_rdata) && sp_r == $past(sp_r) + srfo_pkg::STACK_STEP
         && state_r == ST_IDLE && op_done)
      else $error("return did not load pc and step sp");

   chk_interrupt_return_sr_first: assert property (
      pop_sr_ack |=> sr_r == $past(mem_rdata) && state_r == ST_POP_PC
         && sp_r == $past(sp_r) + srfo_pkg::STACK_STEP)
      else $error("interrupt return did not restore status first");

   chk_interrupt_return_sequence: assert property (
      (taken && op_req.op == srfo_pkg::OP_INTERRUPT_RETURN)
         |=> state_r == ST_POP_SR && mem_addr == $past(sp_r))
      else $error("interrupt return did not start with status pop");

   chk_shl_carry: assert property (
      (taken && op_req.op == srfo_pkg::OP_ARITH_SHIFT_LEFT && !op_req.byte_op)
         |=> !result[0] && sr_r[srfo_pkg::C_BIT] == $past(op_req.operand[15]))
      else $error("shift left carry or lsb wrong");

   chk_ovf_word: assert property (
      (taken && !op_req.byte_op && (op_req.op == srfo_pkg::OP_ARITH_SHIFT_LEFT
         || op_req.op == srfo_pkg::OP_ROTATE_LEFT_THRU_CARRY))
         |=> sr_r[srfo_pkg::V_BIT] == ($past(op_req.operand[15]) != $past(op_req.operand[14])))
      else $error("word left shift overflow wrong");

   chk_ovf_byte: assert property (
      (taken && op_req.byte_op && (op_req.op == srfo_pkg::OP_ARITH_SHIFT_LEFT
         || op_req.op == srfo_pkg::OP_ROTATE_LEFT_THRU_CARRY))
         |=> sr_r[srfo_pkg::V_BIT] == ($past(op_req.operand[7]) != $past(op_req.operand[6])))
      else $error("byte left shift overflow wrong");

   chk_flags_nz: assert property (
      (taken && is_alu && !op_req.byte_op) |=> result_valid
         && sr_r[srfo_pkg::Z_BIT] == (result == 16'h0000) && sr_r[srfo_pkg::N_BIT] == result[15])
      else $error("negative or zero flag wrong");

   chk_right_carry: assert property (
      (taken && (op_req.op == srfo_pkg::OP_ARITH_SHIFT_RIGHT
         || op_req.op == srfo_pkg::OP_ROTATE_RIGHT_THRU_CARRY))
         |=> !sr_r[srfo_pkg::V_BIT] && sr_r[srfo_pkg::C_BIT] == $past(op_req.operand[0]))
      else $error("right shift carry or overflow wrong");

   chk_byte_upper: assert property (
      (taken && is_alu && op_req.byte_op && op_req.dst_is_reg) |=> result[15:8] == 8'h00)
      else $error("byte register result upper byte not cleared");

   chk_sbc_carry: assert property (
      (taken && op_req.op == srfo_pkg::OP_SUBTRACT_BORROW_ONLY && !op_req.byte_op)
         |=> sr_r[srfo_pkg::C_BIT] == ($past(op_req.operand) != 16'h0000
            || $past(sr_r[srfo_pkg::C_BIT])))
      else $error("borrow subtract carry wrong");

   chk_force_neg: assert property (
      (taken && op_req.op == srfo_pkg::OP_FORCE_NEGATIVE_FLAG)
         |=> sr_r == ($past(sr_r) | srfo_pkg::SET_N_MASK))
      else $error("force negative changed other bits");

   chk_mode_keep: assert property (
      (taken && !is_ret) |=> sr_r[srfo_pkg::OSCILLATOR_OFF_BIT_BIT:srfo_pkg::GIE_BIT]
         == $past(sr_r[srfo_pkg::OSCILLATOR_OFF_BIT_BIT:srfo_pkg::GIE_BIT]))
      else $error("mode bits disturbed");

   cov_ret: cover property (
      (taken && op_req.op == srfo_pkg::OP_SUBROUTINE_RETURN) ##[1:20] pop_pc_ack);

   cov_interrupt_return: cover property (pop_sr_ack ##[1:20] pop_pc_ack);

   cov_byte_sbc: cover property (
      taken && op_req.op == srfo_pkg::OP_SUBTRACT_BORROW_ONLY && op_req.byte_op);

endmodule

// File: verilog/srfo_pkg.sv
// shared types and constants for the shift/return/flag execution unit
// assumes a 16-bit core with a word-wide stack read port
package srfo_pkg;

   // operations the unit executes
   typedef enum logic [3:0] {
      OP_SUBROUTINE_RETURN,
      OP_INTERRUPT_RETURN,
      OP_ARITH_SHIFT_LEFT,
      OP_ROTATE_LEFT_THRU_CARRY,
      OP_ARITH_SHIFT_RIGHT,
      OP_ROTATE_RIGHT_THRU_CARRY,
      OP_SUBTRACT_BORROW_ONLY,
      OP_FORCE_CARRY_FLAG,
      OP_FORCE_NEGATIVE_FLAG,
      OP_FORCE_ZERO_FLAG
   } srfo_op_e;

   // status register bit positions
   localparam int unsigned C_BIT      = 0;
   localparam int unsigned Z_BIT      = 1;
   localparam int unsigned N_BIT      = 2;
   localparam int unsigned GIE_BIT    = 3;
   localparam int unsigned PROCESSOR_OFF_BIT_BIT = 4;
   localparam int unsigned OSCILLATOR_OFF_BIT_BIT = 5;
   localparam int unsigned V_BIT      = 8;

   // or-masks of the flag forcing operations
   localparam logic [15:0] SET_C_MASK = 16'h0001;
   localparam logic [15:0] SET_Z_MASK = 16'h0002;
   localparam logic [15:0] SET_N_MASK = 16'h0004;

   // stack pointer step per pop
   localparam logic [15:0] STACK_STEP = 16'h0002;

   // overflow windows of the left shifts
   localparam logic [15:0] OVF_W_LO = 16'h4000;
   localparam logic [15:0] OVF_W_HI = 16'hC000;
   localparam logic [7:0]  OVF_B_LO = 8'h40;
   localparam logic [7:0]  OVF_B_HI = 8'hC0;

   // all-ones addends of the borrow-only subtract
   localparam logic [15:0] ONES_W = 16'hFFFF;
   localparam logic [7:0]  ONES_B = 8'hFF;

   // values after reset
   localparam logic [15:0] RST_PC = 16'h0000;
   localparam logic [15:0] RST_SP = 16'h0400;
   localparam logic [15:0] RST_SR = 16'h0000;

   typedef struct packed {
      srfo_op_e    op;
      logic        byte_op;
      logic        dst_is_reg;
      logic [15:0] operand;
   } srfo_req_s;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] sr;
   } srfo_ld_s;

endpackage
